// file: pkg/ddsreg_pkg.sv
// Constants for the synthesizer configuration register bank.
// Assumes a serial port engine that presents decoded register accesses.
// Operation
// - Decode six registers at offsets 0x00-0x05.
// - Amplitude scale: 2-bit speed, 14-bit factor.
// - Load bit clear: timer reloads only at one or zero.
// - Load bit set: reload on timeout or commit.
// - Keying enable clear bypasses amplitude scaling.
// - Enable set: mode bit picks manual/automatic.
// - Manual mode scales every sample by factor.
// - Auto mode: key high ramps up to factor.
// - Auto mode: key low ramps down to zero.
// - Alignment bit set flags each reference rising edge.
// - Writes buffered, applied on commit, start cleared.
// - Host reads and writes every register.
// - Speed code sets steps per ramp increment.
package ddsreg_pkg;
  localparam logic [2:0]  ADDR_CTRL_ONE    = 3'h0;
  localparam logic [2:0]  ADDR_CTRL_TWO    = 3'h1;
  localparam logic [2:0]  ADDR_AMP_SCALE   = 3'h2;
  localparam logic [2:0]  ADDR_RAMP_INTVL  = 3'h3;
  localparam logic [2:0]  ADDR_TUNING      = 3'h4;
  localparam logic [2:0]  ADDR_PHASE       = 3'h5;
  localparam int          CTRL_ONE_W       = 32;
  localparam int          CTRL_TWO_W       = 24;
  localparam int          AMP_SCALE_W      = 16;
  localparam int          RAMP_INTVL_W     = 8;
  localparam int          TUNING_W         = 32;
  localparam int          PHASE_W          = 16;
  localparam int          AMP_W            = 14;
  localparam int          BIT_RAMP_LOAD    = 26;
  localparam int          BIT_KEY_ENABLE   = 25;
  localparam int          BIT_KEY_AUTO     = 24;
  localparam int          BIT_ALIGN_EN     = 23;
  localparam int          SPEED_LSB        = 14;
  localparam logic [31:0] CTRL_ONE_RST     = 32'h0000_0000;
  localparam logic [23:0] CTRL_TWO_RST     = 24'h00_0000;
  localparam logic [15:0] AMP_SCALE_RST    = 16'h0000;
  localparam logic [7:0]  RAMP_INTVL_RST   = 8'h00;
  localparam logic [31:0] TUNING_RST       = 32'h0000_0000;
  localparam logic [15:0] PHASE_RST        = 16'h0000;
  localparam logic [7:0]  TIMER_TIMEOUT    = 8'h01;
endpackage

// file: rtl/ddsreg_ramp_timer.sv
// Amplitude ramp timer: counts down from the ramp interval, pulses a step.
// Assumes interval and control inputs come from the active register set.
`timescale 1ns/100ps
module ddsreg_ramp_timer
  import ddsreg_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  // Control
  input  wire logic [RAMP_INTVL_W-1:0] interval,
  input  wire logic                    load_on_commit,
  input  wire logic                    commit,
  // Step
  output logic                         step
);
  logic [RAMP_INTVL_W-1:0] count_reg;
  logic [RAMP_INTVL_W-1:0] count_next;
  wire  timeout = (count_reg <= TIMER_TIMEOUT);
  // A zero interval still times out every cycle rather than hanging
  wire  reload  = timeout || (load_on_commit && commit);

  assign count_next = reload ? interval : count_reg - 8'h01;
  assign step       = timeout;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= RAMP_INTVL_RST;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

// file: rtl/ddsreg_bank.sv
// Configuration register bank with buffered writes and shaped keying.
// Assumes a serial port engine delivering one-cycle register strobes on
// clk_sys; commit, keying and alignment come from pins and are synchronised.
`timescale 1ns/100ps
module ddsreg_bank
  import ddsreg_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  // Register access from the serial port engine
  input  wire logic                   reg_wr,
  input  wire logic [2:0]             reg_wr_addr,
  input  wire logic [31:0]            reg_wr_data,
  input  wire logic [2:0]             reg_rd_addr,
  output logic      [31:0]            reg_rd_data,
  // Pins
  input  wire logic                   commit_pin,
  input  wire logic                   shaped_keying_pin,
  input  wire logic                   align_ref_pin,
  // Datapath
  input  wire logic [AMP_W-1:0]       sample_in,
  output logic      [AMP_W-1:0]       sample_out,
  // Active configuration
  output logic      [CTRL_ONE_W-1:0]  control_word_one,
  output logic      [CTRL_TWO_W-1:0]  control_word_two,
  output logic      [TUNING_W-1:0]    tuning_word,
  output logic      [PHASE_W-1:0]     phase_offset,
  output logic      [AMP_W-1:0]       amp_level,
  output logic                        align_active,
  output logic                        align_event
);
  // Buffered (written) copies
  logic [CTRL_ONE_W-1:0]   cw1_buf_reg;
  logic [CTRL_TWO_W-1:0]   cw2_buf_reg;
  logic [AMP_SCALE_W-1:0]  asf_buf_reg;
  logic [RAMP_INTVL_W-1:0] arr_buf_reg;
  logic [TUNING_W-1:0]     ftw_buf_reg;
  logic [PHASE_W-1:0]      pow_buf_reg;
  // Active copies
  logic [CTRL_ONE_W-1:0]   cw1_reg;
  logic [CTRL_TWO_W-1:0]   cw2_reg;
  logic [AMP_SCALE_W-1:0]  asf_reg;
  logic [RAMP_INTVL_W-1:0] arr_reg;
  logic [TUNING_W-1:0]     ftw_reg;
  logic [PHASE_W-1:0]      pow_reg;
  // Synchronisers
  logic [1:0]              commit_sync_reg;
  logic                    commit_last_reg;
  logic [1:0]              key_sync_reg;
  logic [1:0]              align_sync_reg;
  logic                    align_last_reg;
  // Keying
  logic [AMP_W-1:0]        amp_reg;
  logic [AMP_W-1:0]        amp_next;
  logic [AMP_W-1:0]        sample_reg;
  logic [31:0]             rd_data_reg;
  logic                    align_event_reg;
  logic                    ramp_step;

  wire wr_cw1 = reg_wr && (reg_wr_addr == ADDR_CTRL_ONE);
  wire wr_cw2 = reg_wr && (reg_wr_addr == ADDR_CTRL_TWO);
  wire wr_asf = reg_wr && (reg_wr_addr == ADDR_AMP_SCALE);
  wire wr_arr = reg_wr && (reg_wr_addr == ADDR_RAMP_INTVL);
  wire wr_ftw = reg_wr && (reg_wr_addr == ADDR_TUNING);
  wire wr_pow = reg_wr && (reg_wr_addr == ADDR_PHASE);

  wire commit = commit_sync_reg[1] && !commit_last_reg;

  // Reads return the buffered value, i.e. what software last wrote
  wire [31:0] rd_mux =
    (reg_rd_addr == ADDR_CTRL_ONE)   ? cw1_buf_reg :
    (reg_rd_addr == ADDR_CTRL_TWO)   ? {8'h00, cw2_buf_reg} :
    (reg_rd_addr == ADDR_AMP_SCALE)  ? {16'h0000, asf_buf_reg} :
    (reg_rd_addr == ADDR_RAMP_INTVL) ? {24'h00_0000, arr_buf_reg} :
    (reg_rd_addr == ADDR_TUNING)     ? ftw_buf_reg :
    (reg_rd_addr == ADDR_PHASE)      ? {16'h0000, pow_buf_reg} :
                                       32'h0000_0000;

  wire key_enable  = cw1_reg[BIT_KEY_ENABLE];
  wire key_auto    = key_enable && cw1_reg[BIT_KEY_AUTO];
  wire [AMP_W-1:0] asf_factor = asf_reg[AMP_W-1:0];
  wire [1:0]       speed_code = asf_reg[SPEED_LSB +: 2];
  // Speed code 0..3 gives 1, 2, 4 or 8 amplitude steps per ramp tick
  wire [AMP_W-1:0] step_size = AMP_W'(14'h0001 << speed_code);
  wire [AMP_W:0]   amp_up    = {1'b0, amp_reg} + {1'b0, step_size};
  wire             key_high  = key_sync_reg[1];

  // Ramp saturates at the factor going up and at zero going down
  assign amp_next =
    !key_auto ? {AMP_W{1'b0}} :
    !ramp_step ? amp_reg :
    key_high ? ((amp_up >= {1'b0, asf_factor}) ? asf_factor : amp_up[AMP_W-1:0]) :
    ((amp_reg <= step_size) ? {AMP_W{1'b0}} : amp_reg - step_size);

  // Scale factor in use: none, manual factor, or ramped level
  wire [AMP_W-1:0] gain = key_auto ? amp_reg : asf_factor;
  wire [2*AMP_W-1:0] product = sample_in * gain;
  wire [AMP_W-1:0] sample_next = key_enable ? product[2*AMP_W-1:AMP_W] : sample_in;

  wire align_on   = cw1_reg[BIT_ALIGN_EN];
  wire align_rise = align_sync_reg[1] && !align_last_reg;

  ddsreg_ramp_timer u_ramp_timer (
    .clk_sys        (clk_sys),
    .arst_n         (arst_n),
    .interval       (arr_reg),
    .load_on_commit (cw1_reg[BIT_RAMP_LOAD]),
    .commit         (commit),
    .step           (ramp_step)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      commit_sync_reg <= 2'b00;
      commit_last_reg <= 1'b0;
      key_sync_reg    <= 2'b00;
      align_sync_reg  <= 2'b00;
      align_last_reg  <= 1'b0;
    end else begin
      commit_sync_reg <= {commit_sync_reg[0], commit_pin};
      commit_last_reg <= commit_sync_reg[1];
      key_sync_reg    <= {key_sync_reg[0], shaped_keying_pin};
      align_sync_reg  <= {align_sync_reg[0], align_ref_pin};
      align_last_reg  <= align_sync_reg[1];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cw1_buf_reg <= CTRL_ONE_RST;
      cw2_buf_reg <= CTRL_TWO_RST;
      asf_buf_reg <= AMP_SCALE_RST;
      arr_buf_reg <= RAMP_INTVL_RST;
      ftw_buf_reg <= TUNING_RST;
      pow_buf_reg <= PHASE_RST;
    end else begin
      if (wr_cw1) cw1_buf_reg <= reg_wr_data;
      if (wr_cw2) cw2_buf_reg <= reg_wr_data[CTRL_TWO_W-1:0];
      if (wr_asf) asf_buf_reg <= reg_wr_data[AMP_SCALE_W-1:0];
      if (wr_arr) arr_buf_reg <= reg_wr_data[RAMP_INTVL_W-1:0];
      if (wr_ftw) ftw_buf_reg <= reg_wr_data;
      if (wr_pow) pow_buf_reg <= reg_wr_data[PHASE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cw1_reg <= CTRL_ONE_RST;
      cw2_reg <= CTRL_TWO_RST;
      asf_reg <= AMP_SCALE_RST;
      arr_reg <= RAMP_INTVL_RST;
      ftw_reg <= TUNING_RST;
      pow_reg <= PHASE_RST;
    end else if (commit) begin
      cw1_reg <= cw1_buf_reg;
      cw2_reg <= cw2_buf_reg;
      asf_reg <= asf_buf_reg;
      arr_reg <= arr_buf_reg;
      ftw_reg <= ftw_buf_reg;
      pow_reg <= pow_buf_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      amp_reg         <= {AMP_W{1'b0}};
      sample_reg      <= {AMP_W{1'b0}};
      rd_data_reg     <= 32'h0000_0000;
      align_event_reg <= 1'b0;
    end else begin
      amp_reg         <= amp_next;
      sample_reg      <= sample_next;
      rd_data_reg     <= rd_mux;
      align_event_reg <= align_on && align_rise;
    end
  end

  assign reg_rd_data      = rd_data_reg;
  assign sample_out       = sample_reg;
  assign control_word_one = cw1_reg;
  assign control_word_two = cw2_reg;
  assign tuning_word      = ftw_reg;
  assign phase_offset     = pow_reg;
  assign amp_level        = amp_reg;
  assign align_active     = align_on;
  assign align_event      = align_event_reg;
endmodule

// file: verif/ddsreg_bank_checker.sv
// Port-level properties of the register bank.
// Assumes binding onto ddsreg_bank; one clock domain.
`timescale 1ns/100ps
module ddsreg_bank_checker
  import ddsreg_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  // Register access
  input wire logic                  reg_wr,
  input wire logic [2:0]            reg_rd_addr,
  input wire logic [31:0]           reg_rd_data,
  // Pins and datapath
  input wire logic                  commit_pin,
  input wire logic                  shaped_keying_pin,
  input wire logic [AMP_W-1:0]      sample_in,
  input wire logic [AMP_W-1:0]      sample_out,
  // Active configuration
  input wire logic [CTRL_ONE_W-1:0] control_word_one,
  input wire logic [CTRL_TWO_W-1:0] control_word_two,
  input wire logic [TUNING_W-1:0]   tuning_word,
  input wire logic [PHASE_W-1:0]    phase_offset,
  input wire logic [AMP_W-1:0]      amp_level,
  input wire logic                  align_event
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire auto_on = control_word_one[BIT_KEY_ENABLE] && control_word_one[BIT_KEY_AUTO];
  property p_rd_unmapped; reg_rd_addr > 3'h5 |=> reg_rd_data == 32'h0000_0000; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_hold; !$past(reg_wr) && $stable(reg_rd_addr) |=> $stable(reg_rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // Active copies may only move three edges after the commit pin rose
  property p_act_hold;
    $changed({control_word_one, control_word_two, tuning_word, phase_offset})
      |-> $past(commit_pin, 3) && !$past(commit_pin, 4);
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("active set moved without commit");
  property p_bypass; !control_word_one[BIT_KEY_ENABLE] |=> sample_out == $past(sample_in); endproperty
  a_bypass: assert property (p_bypass) else $error("bypass sample wrong");
  property p_auto_scale;
    auto_on |=> sample_out == AMP_W'((28'($past(sample_in)) * 28'($past(amp_level))) >> AMP_W);
  endproperty
  a_auto_scale: assert property (p_auto_scale) else $error("auto scaled sample wrong");
  property p_amp_off; !auto_on |=> amp_level == '0; endproperty
  a_amp_off: assert property (p_amp_off) else $error("ramp level outside auto mode");
  property p_ramp_up;
    amp_level > $past(amp_level)
      |-> $past(shaped_keying_pin, 2) || $past(shaped_keying_pin, 3) || $past(shaped_keying_pin, 4);
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("ramp rose with key low");
  property p_ramp_down;
    auto_on && $past(auto_on) && amp_level < $past(amp_level)
      |-> !$past(shaped_keying_pin, 2) || !$past(shaped_keying_pin, 3) || !$past(shaped_keying_pin, 4);
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("ramp fell with key high");
  property p_align_evt; align_event |-> control_word_one[BIT_ALIGN_EN]; endproperty
  a_align_evt: assert property (p_align_evt) else $error("alignment while disabled");
endmodule
bind ddsreg_bank ddsreg_bank_checker i_chk (.*);

// file: verif/ddsreg_host_model.sv
// Host model: register strobes, read address and commit pin.
// Assumes the bank samples on rising clk_sys; all changes at falling edges.
`timescale 1ns/100ps
module ddsreg_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Register access
  input  wire logic [31:0] reg_rd_data,
  output logic             reg_wr,
  output logic [2:0]       reg_wr_addr,
  output logic [31:0]      reg_wr_data,
  output logic [2:0]       reg_rd_addr,
  // Commit pin
  output logic             commit_pin
);
  initial begin
    reg_wr = 1'b0;
    reg_wr_addr = 3'h0;
    reg_wr_data = 32'h0000_0000;
    reg_rd_addr = 3'h0;
    commit_pin = 1'b0;
  end
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr_addr = a;
    reg_wr_data = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wr_data = ~d; // Stale data must not look valid
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    reg_rd_addr = a;
    @(negedge clk_sys);
    d = reg_rd_data;
  endtask
  // Pin low afterwards long enough for the sync chain to settle
  task automatic commit();
    @(negedge clk_sys);
    commit_pin = 1'b1;
    repeat (2) @(negedge clk_sys);
    commit_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule

// file: verif/tb.sv
// Self-checking bench for the register bank.
// Assumes the host model drives the register side and the commit pin.
`timescale 1ns/100ps
module tb
  import ddsreg_pkg::*;
;
  logic clk_sys, arst_n, reg_wr, commit_pin, shaped_keying_pin, align_ref_pin;
  logic [2:0] reg_wr_addr, reg_rd_addr;
  logic [31:0] reg_wr_data, reg_rd_data, control_word_one, tuning_word;
  logic [AMP_W-1:0] sample_in, sample_out, amp_level;
  logic [CTRL_TWO_W-1:0] control_word_two;
  logic [PHASE_W-1:0] phase_offset;
  logic align_active, align_event;
  int n_fail, n_checks, cyc, n;
  int wid[6] = '{32, 24, 16, 8, 32, 16};
  ddsreg_host_model i_ddsreg_host_model (.*);
  ddsreg_bank i_ddsreg_bank (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic s_regs();
    logic [31:0] d;
    for (int a = 0; a < 7; a++) begin
      i_ddsreg_host_model.rd(3'(a), d);
      check(d, 32'h0000_0000);
    end
    for (int a = 0; a < 7; a++) i_ddsreg_host_model.wr(3'(a), 32'hA5C3_9E70 + 32'(a));
    for (int a = 0; a < 7; a++) begin
      i_ddsreg_host_model.rd(3'(a), d);
      check(d, a > 5 ? 32'h0 : 32'((64'hA5C3_9E70 + a) & ((64'h1 << wid[a]) - 1)));
    end
    check(tuning_word, 32'h0000_0000);
    i_ddsreg_host_model.commit();
    check(tuning_word, 32'hA5C3_9E74);
    check(control_word_one, 32'hA5C3_9E70);
    check({8'h00, control_word_two}, 32'h00C3_9E71);
    check({16'h0000, phase_offset}, 32'h0000_9E75);
  endtask
  task automatic s_manual();
    sample_in = 14'h3FFE;
    i_ddsreg_host_model.wr(ADDR_AMP_SCALE, 32'h0000_2000);
    i_ddsreg_host_model.wr(ADDR_CTRL_ONE, 32'h0200_0000);
    i_ddsreg_host_model.commit();
    check(32'(sample_out), 32'h0000_1FFF);
    i_ddsreg_host_model.wr(ADDR_CTRL_ONE, 32'h0100_0000);
    i_ddsreg_host_model.commit();
    check(32'(sample_out), 32'h0000_3FFE);
  endtask
  // Speed code 1 gives steps of two up to a ceiling of six.
  // The timer still runs on the old long interval; only the second commit,
  // with the load bit already active, restarts it at the short one.
  task automatic s_auto();
    i_ddsreg_host_model.wr(ADDR_AMP_SCALE, 32'h0000_4006);
    i_ddsreg_host_model.wr(ADDR_RAMP_INTVL, 32'h0000_0004);
    i_ddsreg_host_model.wr(ADDR_CTRL_ONE, 32'h0700_0000);
    i_ddsreg_host_model.commit();
    i_ddsreg_host_model.commit();
    check(32'(amp_level), 32'h0000_0000);
    shaped_keying_pin = 1'b1;
    n = 0;
    while (amp_level !== 14'h0002 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(amp_level), 32'h0000_0002);
    n = 0;
    while (amp_level === 14'h0002 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n), 32'h0000_0004);
    check(32'(amp_level), 32'h0000_0004);
    repeat (20) @(negedge clk_sys);
    check(32'(amp_level), 32'h0000_0006);
    shaped_keying_pin = 1'b0;
    repeat (30) @(negedge clk_sys);
    check(32'(amp_level), 32'h0000_0000);
  endtask
  task automatic s_align();
    i_ddsreg_host_model.wr(ADDR_CTRL_ONE, 32'h0080_0000);
    i_ddsreg_host_model.commit();
    check(32'(align_active), 32'h0000_0001);
    align_ref_pin = 1'b1;
    n = 0;
    while (align_event !== 1'b1 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(align_event), 32'h0000_0001);
    align_ref_pin = 1'b0;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    arst_n = 1'b0;
    shaped_keying_pin = 1'b0;
    align_ref_pin = 1'b0;
    sample_in = 14'h0000;
    repeat (6) @(negedge clk_sys);
    arst_n = 1'b1;
    s_regs();
    s_manual();
    s_auto();
    s_align();
    wrap_up();
  end
endmodule
